// >>> media_select_inline_power_detect_bench.sv
// testbench: apb-driven checks of media autoselect and inline power detection
`timescale 1ns/1ps
module media_select_inline_power_detect_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        strap = 1'b1;
    logic        cu_ok = 1'b0;
    logic        sd_ok = 1'b0;
    logic        unpowered = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, flp_lb, flp_tx, an_run, cu_blk, r125, irq, err;
    logic [1:0]  media, smode, exp;
    int          fails = 0;
    int          tests_run = 0;
    int          n;
    msipd_top #(.IPD_WINDOW(20)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clock_speed_strap(strap),
        .cu_link_ok(cu_ok), .sd_link_ok(sd_ok), .flp_loopback(flp_lb), .flp_special_tx(flp_tx), .an_run(an_run),
        .cu_link_block(cu_blk), .media_autoselect(media), .serdes_mode(smode), .ref_clk_125(r125), .irq(irq)
    );
    msipd_cable_lp u_lp (
        .pclk(pclk), .presetn(presetn), .unpowered(unpowered), .slow(slow), .flp_special_tx(flp_tx),
        .flp_loopback(flp_lb)
    );
    always #2.5 pclk = ~pclk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, want, seen);
        end
    endtask
    // one apb transfer, then an idle edge so the next call never re-drives psel in the same step
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait count assumed; only the hang guard ends a stuck access
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, msipd_pkg::REG_MISC_IDX, 32'h0);
        chk("strap", rd & 32'h1, 32'h1);
        chk("ref_clk_125", 32'(r125), 32'h1);
        apb(1'b0, msipd_pkg::REG_CTRL_AN_IDX, 32'h0);
        chk("ctrl_reset", rd, msipd_pkg::CTRL_AN_RST);
        chk("mapped_ok", {31'h0, err}, 32'h0);
        apb(1'b0, 8'h3F, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        // every link case under both preferences; the mode field walks all four modes
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, msipd_pkg::REG_MEDIA_PREF_IDX, {20'h0, i[2], 9'h0, i[1:0]});
            cu_ok <= i[1];
            sd_ok <= i[0];
            repeat (2) @(posedge pclk);
            exp = (i[1:0] == 2'b00) ? msipd_pkg::MEDIA_NONE
                : (i[0] && (i[2] || !i[1])) ? msipd_pkg::MEDIA_SERDES : msipd_pkg::MEDIA_COPPER;
            chk("media", 32'(media), 32'(exp));
            chk("serdes_mode", 32'(smode), 32'(i[1:0]));
            chk("cu_block", 32'(cu_blk), 32'(i[2] & i[0]));
            apb(1'b0, msipd_pkg::REG_MEDIA_STAT_IDX, 32'h0);
            chk("media_stat", (rd >> 6) & 32'h3, 32'(exp));
        end
        // serdes preferred: active copper gives way once serdes links
        sd_ok <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("cu_active", 32'(media), 32'(msipd_pkg::MEDIA_COPPER));
        sd_ok <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("sd_takes_over", 32'(media), 32'(msipd_pkg::MEDIA_SERDES));
        apb(1'b1, msipd_pkg::REG_MEDIA_PREF_IDX, 32'h0);
        cu_ok <= 1'b0;
        sd_ok <= 1'b0;
        repeat (3) @(posedge pclk);
        // events flagged but masked, then cleared
        apb(1'b0, msipd_pkg::REG_IRQ_STAT_IDX, 32'h0);
        chk("media_event", rd & 32'h1, 32'h1);
        chk("masked_irq", 32'(irq), 32'h0);
        apb(1'b1, msipd_pkg::REG_IRQ_CLR_IDX, 32'h0000_0203);
        apb(1'b0, msipd_pkg::REG_IRQ_STAT_IDX, 32'h0);
        chk("cleared", rd, 32'h0);
        // powered partner: search runs out, autoneg follows
        apb(1'b1, msipd_pkg::REG_IRQ_EN_IDX, 32'h0000_0200);
        apb(1'b1, msipd_pkg::REG_CTRL_AN_IDX, 32'h0000_1000);
        apb(1'b1, msipd_pkg::REG_IPD_IDX, 32'h0000_0400);
        for (n = 0; n < 50 && flp_tx !== 1'b1; n++) @(posedge pclk);
        apb(1'b0, msipd_pkg::REG_IPD_IDX, 32'h0);
        chk("searching", (rd >> 8) & 32'h3, 32'(msipd_pkg::IPD_SEARCH));
        for (n = 0; n < 100 && an_run !== 1'b1; n++) @(posedge pclk);
        apb(1'b0, msipd_pkg::REG_IPD_IDX, 32'h0);
        chk("timed_out", (rd >> 8) & 32'h3, 32'(msipd_pkg::IPD_TIMEOUT));
        chk("an_after_window", {30'h0, an_run, flp_tx}, 32'h2);
        chk("no_irq", 32'(irq), 32'h0);
        cu_ok <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, msipd_pkg::REG_LINK_STAT_IDX, 32'h0);
        chk("link_up", (rd >> 2) & 32'h1, 32'h1);
        // link lost while the partner now waits for power, answering late
        unpowered <= 1'b1;
        slow <= 1'b1;
        cu_ok <= 1'b0;
        for (n = 0; n < 50 && flp_tx !== 1'b1; n++) @(posedge pclk);
        chk("search_again", {30'h0, an_run, flp_tx}, 32'h1);
        for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge pclk);
        apb(1'b0, msipd_pkg::REG_IPD_IDX, 32'h0);
        chk("needs_power", (rd >> 8) & 32'h3, 32'(msipd_pkg::IPD_FOUND));
        unpowered <= 1'b0;
        for (n = 0; n < 100 && an_run !== 1'b1; n++) @(posedge pclk);
        apb(1'b1, msipd_pkg::REG_IRQ_CLR_IDX, 32'h0000_0003);
        apb(1'b0, msipd_pkg::REG_IRQ_STAT_IDX, 32'h0);
        chk("flag_set", rd, 32'h0000_0200);
        chk("irq_dropped", 32'(irq), 32'h0);
        apb(1'b0, msipd_pkg::REG_IRQ_STAT_IDX, 32'h0);
        chk("flag_gone", rd, 32'h0);
        stop_test();
    end
endmodule

// >>> msipd_cable_lp.sv
// partner: cable link partner that loops search pulses back while unpowered
`timescale 1ns/1ps
module msipd_cable_lp (
    input  wire logic pclk,           // clock
    input  wire logic presetn,        // reset, active low
    input  wire logic unpowered,      // partner waits for power
    input  wire logic slow,           // late loopback
    input  wire logic flp_special_tx, // search pulses sent
    output logic      flp_loopback    // pulses returned
);
    logic [2:0] echo_q;
    // loop delay line; a powered partner never echoes the pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            echo_q <= 3'h0;
        end else begin
            echo_q <= {echo_q[1:0], flp_special_tx & unpowered};
        end
    end
    assign flp_loopback = slow ? echo_q[2] : echo_q[0];
endmodule

// >>> msipd_media_arb.sv
// media arbiter: picks copper or serdes from preference and link states
`timescale 1ns/1ps
module msipd_media_arb (
    input  wire logic       pclk,         // system clock
    input  wire logic       presetn,      // async reset, active low
    input  wire logic       pref_serdes,  // 1 prefers serdes
    input  wire logic       cu_link,      // copper link up
    input  wire logic       sd_link,      // serdes link up
    output logic      [1:0] media_sel,    // chosen media code
    output logic            cu_block      // copper held off / dropped
);
    typedef struct packed {
        logic [1:0] sel;
    } msipd_arb_t;

    msipd_arb_t st_q, st_d;

    // preferred medium wins; the other only while preferred is down
    always_comb begin
        st_d = st_q;
        if (pref_serdes) begin
            if (sd_link) st_d.sel = msipd_pkg::MEDIA_SERDES;
            else if (cu_link) st_d.sel = msipd_pkg::MEDIA_COPPER;
            else st_d.sel = msipd_pkg::MEDIA_NONE;
        end else begin
            if (cu_link) st_d.sel = msipd_pkg::MEDIA_COPPER;
            else if (sd_link) st_d.sel = msipd_pkg::MEDIA_SERDES;
            else st_d.sel = msipd_pkg::MEDIA_NONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) st_q <= '{sel: 2'h0};
        else st_q <= st_d;
    end

    assign media_sel = st_q.sel;
    // copper may not link while serdes is up with serdes preferred
    assign cu_block  = pref_serdes & sd_link;
endmodule

// >>> msipd_pkg.sv
// package: register map, field positions, reset values and timing counts for media select / inline power detect
package msipd_pkg;
    // register indices as printed; byte address is index * 4
    localparam logic [7:0]  REG_CTRL_AN_IDX   = 8'h00;  // register 0
    localparam logic [7:0]  REG_LINK_STAT_IDX = 8'h01;  // register 1
    localparam logic [7:0]  REG_MEDIA_STAT_IDX = 8'h20; // register 20E1
    localparam logic [7:0]  REG_MEDIA_PREF_IDX = 8'h17; // register 23
    localparam logic [7:0]  REG_IPD_IDX       = 8'h18;  // register 23E1
    localparam logic [7:0]  REG_IRQ_STAT_IDX  = 8'h1A;  // register 26
    localparam logic [7:0]  REG_IRQ_CLR_IDX   = 8'h30;
    localparam logic [7:0]  REG_IRQ_EN_IDX    = 8'h31;
    localparam logic [7:0]  REG_MISC_IDX      = 8'h32;

    // field positions
    localparam int AN_EN_BIT       = 12;
    localparam int LINK_UP_BIT     = 2;
    localparam int MEDIA_SEL_LSB   = 6;
    localparam int MEDIA_PREF_BIT  = 11;
    localparam int AMS_MODE_LSB    = 0;
    localparam int IPD_EN_BIT      = 10;
    localparam int IPD_STAT_LSB    = 8;
    localparam int IRQ_IPD_BIT     = 9;
    localparam int IRQ_MEDIA_BIT   = 0;
    localparam int IRQ_LINKDN_BIT  = 1;
    localparam int MISC_REFCLK_BIT = 0;

    // reset values
    localparam logic [31:0] CTRL_AN_RST    = 32'h0000_1000;
    localparam logic [31:0] MEDIA_PREF_RST = 32'h0000_0000;
    localparam logic [31:0] IPD_RST        = 32'h0000_0000;
    localparam logic [31:0] IRQ_EN_RST     = 32'h0000_0000;

    // media selection codes
    localparam logic [1:0] MEDIA_NONE   = 2'h0;
    localparam logic [1:0] MEDIA_COPPER = 2'h1;
    localparam logic [1:0] MEDIA_SERDES = 2'h2;

    // inline power detection status codes
    localparam logic [1:0] IPD_SEARCH  = 2'h0;
    localparam logic [1:0] IPD_FOUND   = 2'h1;
    localparam logic [1:0] IPD_TIMEOUT = 2'h2;

    // serdes media modes behind the mac
    localparam logic [1:0] AMS_1000BX   = 2'h0;
    localparam logic [1:0] AMS_100FX    = 2'h1;
    localparam logic [1:0] AMS_SGMII_PT = 2'h2;
    localparam logic [1:0] AMS_SGMII_AN = 2'h3;

    // detection window
    localparam int CLK_MHZ       = 200;
    localparam int IPD_WINDOW_US = 100;
    localparam int IPD_WINDOW_CYC = IPD_WINDOW_US * CLK_MHZ;
endpackage

// >>> msipd_props.sv
// checker: port-level properties of media autoselect and inline power detection
`timescale 1ns/1ps
module msipd_props #(
    parameter int IPD_WINDOW = msipd_pkg::IPD_WINDOW_CYC  // detection window in cycles
) (
    input wire logic        pclk,                  // clock
    input wire logic        presetn,               // reset, active low
    input wire logic        psel,                  // apb select
    input wire logic        penable,               // apb enable
    input wire logic        pwrite,                // apb direction
    input wire logic [11:0] paddr,                 // apb address
    input wire logic [31:0] prdata,                // apb read data
    input wire logic        ref_clock_speed_strap, // speed strap
    input wire logic        cu_link_ok,            // copper link
    input wire logic        sd_link_ok,            // serdes link
    input wire logic        flp_loopback,          // looped pulses
    input wire logic        flp_special_tx,        // search running
    input wire logic        an_run,                // autoneg running
    input wire logic        cu_link_block,         // copper held down
    input wire logic [1:0]  media_autoselect,      // chosen media
    input wire logic        ref_clk_125,           // latched speed
    input wire logic        irq                    // interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] srch_q;
    logic [15:0] srch_d;
    // length of the running search; a stuck window would never end otherwise
    always_comb srch_d = flp_special_tx ? srch_q + 16'h0001 : 16'h0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srch_q <= 16'h0000;
        end else begin
            srch_q <= srch_d;
        end
    end
    // status read of the flag register, seeing only the detection flag
    sequence flag_read;
        psel && penable && !pwrite && paddr == {2'b00, msipd_pkg::REG_IRQ_STAT_IDX, 2'b00};
    endsequence
    sequence only_ipd_flag;
        prdata == 32'h0000_0200 && !flp_loopback;
    endsequence
    strap_latch_a: assert property (
        !$past(presetn, 2) && $past(presetn) |-> ref_clk_125 == $past(ref_clock_speed_strap))
        else $error("speed strap not latched");
    strap_hold_a: assert property ($past(presetn, 2) |-> $stable(ref_clk_125))
        else $error("latched speed moved");
    sd_alone_a: assert property (
        sd_link_ok && !cu_link_ok |=> media_autoselect == msipd_pkg::MEDIA_SERDES)
        else $error("lone serdes link not chosen");
    no_link_a: assert property (
        !sd_link_ok && !cu_link_ok |=> media_autoselect == msipd_pkg::MEDIA_NONE)
        else $error("media shown without link");
    serdes_wins_a: assert property (
        cu_link_block |=> media_autoselect == msipd_pkg::MEDIA_SERDES)
        else $error("preferred serdes not active");
    block_cause_a: assert property (
        cu_link_block && cu_link_ok |=> media_autoselect != msipd_pkg::MEDIA_COPPER)
        else $error("copper linked while serdes held it off");
    search_an_a: assert property (flp_special_tx |-> !an_run)
        else $error("search and autoneg together");
    search_bound_a: assert property (srch_q <= IPD_WINDOW + 2)
        else $error("detection window overran");
    search_end_a: assert property (
        $fell(flp_special_tx) && srch_q >= IPD_WINDOW - 4 |-> an_run)
        else $error("autoneg not started after window");
    flag_clear_a: assert property (
        flag_read ##0 only_ipd_flag |=> !irq || $changed(media_autoselect))
        else $error("interrupt held after flag read");
endmodule
bind msipd_top msipd_props #(.IPD_WINDOW(IPD_WINDOW)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .ref_clock_speed_strap(ref_clock_speed_strap), .cu_link_ok(cu_link_ok),
    .sd_link_ok(sd_link_ok), .flp_loopback(flp_loopback), .flp_special_tx(flp_special_tx), .an_run(an_run),
    .cu_link_block(cu_link_block), .media_autoselect(media_autoselect), .ref_clk_125(ref_clk_125), .irq(irq)
);

// >>> msipd_top.sv
// top: apb registers, media autoselect and inline powered device detection for one port
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module msipd_top #(
    parameter int IPD_WINDOW = msipd_pkg::IPD_WINDOW_CYC  // detection window in cycles
) (
    input  wire logic        pclk,                  // apb clock, 200 MHz
    input  wire logic        presetn,               // async reset, active low
    input  wire logic        psel,                  // apb select
    input  wire logic        penable,               // apb enable
    input  wire logic        pwrite,                // apb direction
    input  wire logic [11:0] paddr,                 // apb byte address
    input  wire logic [31:0] pwdata,                // apb write data
    output logic      [31:0] prdata,                // apb read data
    output logic             pready,                // apb ready
    output logic             pslverr,               // apb error
    input  wire logic        ref_clock_speed_strap, // 0: 25 MHz, 1: 125 MHz
    input  wire logic        cu_link_ok,            // copper receiver link good
    input  wire logic        sd_link_ok,            // serdes receiver link good
    input  wire logic        flp_loopback,          // looped special pulses seen
    output logic             flp_special_tx,        // send special fast link pulses
    output logic             an_run,                // normal autonegotiation running
    output logic             cu_link_block,         // hold copper link down
    output logic      [1:0]  media_autoselect,      // chosen media
    output logic      [1:0]  serdes_mode,           // serdes media mode
    output logic             ref_clk_125,           // latched reference speed
    output logic             irq                    // interrupt, active high level
);
    initial begin
        if (IPD_WINDOW < 1 || IPD_WINDOW > 32'h0FFF_FFFF)
            $error("IPD_WINDOW out of range");
    end

    typedef enum logic [2:0] {
        IPD_IDLE = 3'b001,
        IPD_SRCH = 3'b010,
        IPD_AN   = 3'b100
    } msipd_state_t;

    typedef struct packed {
        msipd_state_t fsm;
        logic [27:0]  win;
        logic [1:0]   ipd_stat;
        logic         an_en;
        logic         pref;
        logic [1:0]   ams_mode;
        logic         ipd_en;
        logic [2:0]   irq_stat;
        logic [2:0]   irq_en;
        logic         refclk;
        logic         strap_done;
        logic [1:0]   media_prev;
        logic         link_prev;
        logic [31:0]  rdata;
    } msipd_regs_t;

    msipd_regs_t r_q, r_d;
    logic [1:0]  media_sel;
    logic        arb_cu_block;
    logic        cu_link_eff;
    logic        link_up;

    // byte address from printed register index
    function automatic logic [11:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'h0, idx, 2'h0};
    endfunction

    // copper link only counts when not held off and detection finished or disabled
    assign cu_link_eff = cu_link_ok & ~arb_cu_block & (r_q.fsm == IPD_AN | ~r_q.ipd_en);

    msipd_media_arb u_arb (
        .pclk        (pclk),
        .presetn     (presetn),
        .pref_serdes (r_q.pref),
        .cu_link     (cu_link_eff),
        .sd_link     (sd_link_ok),
        .media_sel   (media_sel),
        .cu_block    (arb_cu_block)
    );

    assign link_up = (media_sel != msipd_pkg::MEDIA_NONE);

    // apb answers in the access cycle; no wait states
    wire apb_wr = psel & penable & pwrite;
    wire apb_rd = psel & penable & ~pwrite;
    wire apb_setup_rd = psel & ~penable & ~pwrite;
    logic addr_ok;

    always_comb begin
        addr_ok = 1'b1;
        case (paddr)
            reg_addr(msipd_pkg::REG_CTRL_AN_IDX),
            reg_addr(msipd_pkg::REG_LINK_STAT_IDX),
            reg_addr(msipd_pkg::REG_MEDIA_STAT_IDX),
            reg_addr(msipd_pkg::REG_MEDIA_PREF_IDX),
            reg_addr(msipd_pkg::REG_IPD_IDX),
            reg_addr(msipd_pkg::REG_IRQ_STAT_IDX),
            reg_addr(msipd_pkg::REG_IRQ_CLR_IDX),
            reg_addr(msipd_pkg::REG_IRQ_EN_IDX),
            reg_addr(msipd_pkg::REG_MISC_IDX): addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // one next-state for all registers, detection engine and irq flags
    always_comb begin
        logic [2:0] ev;
        logic       rd_irq;
        ev     = 3'h0;
        rd_irq = apb_rd & (paddr == reg_addr(msipd_pkg::REG_IRQ_STAT_IDX));
        r_d    = r_q;

        // strap caught once after reset release, not under reset
        if (!r_q.strap_done) begin
            r_d.refclk     = ref_clock_speed_strap;
            r_d.strap_done = 1'b1;
        end

        // software writes
        if (apb_wr) begin
            case (paddr)
                reg_addr(msipd_pkg::REG_CTRL_AN_IDX):
                    r_d.an_en = pwdata[msipd_pkg::AN_EN_BIT];
                reg_addr(msipd_pkg::REG_MEDIA_PREF_IDX): begin
                    r_d.pref     = pwdata[msipd_pkg::MEDIA_PREF_BIT];
                    r_d.ams_mode = pwdata[msipd_pkg::AMS_MODE_LSB +: 2];
                end
                reg_addr(msipd_pkg::REG_IPD_IDX): begin
                    r_d.ipd_en = pwdata[msipd_pkg::IPD_EN_BIT];
                    // autoneg starts straight out of reset, so a fresh enable must pull it back to search
                    if (pwdata[msipd_pkg::IPD_EN_BIT] && !r_q.ipd_en)
                        r_d.fsm = IPD_IDLE;
                end
                reg_addr(msipd_pkg::REG_IRQ_EN_IDX):
                    r_d.irq_en = {pwdata[msipd_pkg::IRQ_IPD_BIT],
                                  pwdata[msipd_pkg::IRQ_LINKDN_BIT],
                                  pwdata[msipd_pkg::IRQ_MEDIA_BIT]};
                default: ;
            endcase
        end

        // detection engine; needs both enable and autonegotiation on
        case (r_q.fsm)
            IPD_IDLE: begin
                if (r_q.ipd_en && r_q.an_en) begin
                    r_d.fsm      = IPD_SRCH;
                    r_d.win      = 28'h0;
                    r_d.ipd_stat = msipd_pkg::IPD_SEARCH;
                end else if (r_q.an_en) begin
                    r_d.fsm = IPD_AN;
                end
            end
            IPD_SRCH: begin
                if (!(r_q.ipd_en && r_q.an_en)) begin
                    r_d.fsm = IPD_IDLE;
                end else if (flp_loopback && r_q.ipd_stat == msipd_pkg::IPD_SEARCH) begin
                    r_d.ipd_stat = msipd_pkg::IPD_FOUND;
                    ev[2]        = 1'b1;
                end else if (r_q.win >= 28'(IPD_WINDOW - 1)) begin
                    // fixed window; found status stays until window ends
                    r_d.ipd_stat = msipd_pkg::IPD_TIMEOUT;
                    r_d.fsm      = IPD_AN;
                end else begin
                    r_d.win = r_q.win + 28'h1;
                end
            end
            IPD_AN: begin
                if (!r_q.an_en) begin
                    r_d.fsm = IPD_IDLE;
                end else if (r_q.ipd_en && r_q.link_prev && !link_up) begin
                    r_d.fsm = IPD_IDLE;
                end
            end
            default: r_d.fsm = IPD_IDLE;
        endcase

        // media change and link loss events
        ev[0]        = (media_sel != r_q.media_prev);
        ev[1]        = r_q.link_prev & ~link_up;
        r_d.media_prev = media_sel;
        r_d.link_prev  = link_up;

        // detection flag clears on read, any flag on write-one clear; a new event wins
        if (rd_irq)
            r_d.irq_stat[2] = 1'b0;
        if (apb_wr && paddr == reg_addr(msipd_pkg::REG_IRQ_CLR_IDX))
            r_d.irq_stat = r_d.irq_stat & ~{pwdata[msipd_pkg::IRQ_IPD_BIT],
                                            pwdata[msipd_pkg::IRQ_LINKDN_BIT],
                                            pwdata[msipd_pkg::IRQ_MEDIA_BIT]};
        r_d.irq_stat = r_d.irq_stat | ev;

        // read data captured in setup so it comes from a flop
        r_d.rdata = 32'h0;
        if (apb_setup_rd) begin
            case (paddr)
                reg_addr(msipd_pkg::REG_CTRL_AN_IDX):
                    r_d.rdata[msipd_pkg::AN_EN_BIT] = r_q.an_en;
                reg_addr(msipd_pkg::REG_LINK_STAT_IDX):
                    r_d.rdata[msipd_pkg::LINK_UP_BIT] = link_up;
                reg_addr(msipd_pkg::REG_MEDIA_STAT_IDX):
                    r_d.rdata[msipd_pkg::MEDIA_SEL_LSB +: 2] = media_sel;
                reg_addr(msipd_pkg::REG_MEDIA_PREF_IDX): begin
                    r_d.rdata[msipd_pkg::MEDIA_PREF_BIT]      = r_q.pref;
                    r_d.rdata[msipd_pkg::AMS_MODE_LSB +: 2]   = r_q.ams_mode;
                end
                reg_addr(msipd_pkg::REG_IPD_IDX): begin
                    r_d.rdata[msipd_pkg::IPD_EN_BIT]        = r_q.ipd_en;
                    r_d.rdata[msipd_pkg::IPD_STAT_LSB +: 2] = r_q.ipd_stat;
                end
                reg_addr(msipd_pkg::REG_IRQ_STAT_IDX): begin
                    r_d.rdata[msipd_pkg::IRQ_IPD_BIT]    = r_q.irq_stat[2] | ev[2];
                    r_d.rdata[msipd_pkg::IRQ_LINKDN_BIT] = r_q.irq_stat[1];
                    r_d.rdata[msipd_pkg::IRQ_MEDIA_BIT]  = r_q.irq_stat[0];
                end
                reg_addr(msipd_pkg::REG_IRQ_EN_IDX): begin
                    r_d.rdata[msipd_pkg::IRQ_IPD_BIT]    = r_q.irq_en[2];
                    r_d.rdata[msipd_pkg::IRQ_LINKDN_BIT] = r_q.irq_en[1];
                    r_d.rdata[msipd_pkg::IRQ_MEDIA_BIT]  = r_q.irq_en[0];
                end
                reg_addr(msipd_pkg::REG_MISC_IDX):
                    r_d.rdata[msipd_pkg::MISC_REFCLK_BIT] = r_q.refclk;
                default: ;
            endcase
        end else if (psel && penable) begin
            r_d.rdata = r_q.rdata; // hold through access phase
        end
    end

    // all state in one register, apart from the media selection held in the arbiter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '{fsm: IPD_IDLE, win: 28'h0, ipd_stat: msipd_pkg::IPD_SEARCH,
                     an_en: msipd_pkg::CTRL_AN_RST[msipd_pkg::AN_EN_BIT],
                     pref: msipd_pkg::MEDIA_PREF_RST[msipd_pkg::MEDIA_PREF_BIT],
                     ams_mode: msipd_pkg::AMS_1000BX,
                     ipd_en: msipd_pkg::IPD_RST[msipd_pkg::IPD_EN_BIT],
                     irq_stat: 3'h0, irq_en: msipd_pkg::IRQ_EN_RST[2:0],
                     refclk: 1'b0, strap_done: 1'b0,
                     media_prev: msipd_pkg::MEDIA_NONE, link_prev: 1'b0,
                     rdata: 32'h0};
        end else begin
            r_q <= r_d;
        end
    end

    // outputs
    assign prdata         = r_q.rdata;
    assign pready         = 1'b1;
    assign pslverr        = psel & penable & ~addr_ok;
    assign flp_special_tx = (r_q.fsm == IPD_SRCH);
    assign an_run         = (r_q.fsm == IPD_AN);
    assign cu_link_block  = arb_cu_block;
    assign media_autoselect = media_sel;
    assign serdes_mode    = r_q.ams_mode;
    assign ref_clk_125    = r_q.refclk;
    // level, high while any enabled flag set
    assign irq            = |(r_q.irq_stat & r_q.irq_en);
endmodule
